// File: src/can_msg_serial_framer.sv
/*
  Serial message framer: packs logged CAN messages into flag-delimited,
  byte-stuffed, checksum-protected frames and sends them as 8N1 bytes.
  Assumes one 50 MHz clock, inputs synchronous to it, and a host that
  destuffs and checks frames itself.
*/
// Functional notes
// - Byte link runs 115200 bit/s, 8 data bits, 1 stop, no parity.
// - Every frame opens and closes with 0x7E, never seen unescaped inside.
// - Order: flag, payload, checksum high then low byte, closing flag.
// - A payload or checksum 0x7E becomes 0x7D then byte with bit 5 flipped.
// - Checksum covers unstuffed payload only, sent as two bytes.
// - Checksum polynomial is x^16 + x^15 + x^2 + 1, 0x8005.
// - First payload byte is the application identifier, data follows.
// - Identifier 1 for received messages, 2 for transmitted ones.
// - Record: seconds 4, milliseconds 2, identifier 4, length 1, data 0-8.
// - Transmitted record has same layout, only identifier differs.
// - Seconds field counts seconds since the Unix epoch.
// - Identifier field bit 29 set exactly for extended identifiers.
// - Multi-byte fields go most significant byte first.
// - Framer active only after CAN-powered boot and later link connect.
`timescale 1ns/10ps
`include "can_framer_regs.svh"
module can_msg_serial_framer #(
  parameter bit CRC_REFLECT = 1'b1,
  parameter logic [15:0] CRC_INIT = `CRC_INIT_DEFAULT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic boot_done,
  input wire logic can_powered,
  input wire logic link_connected,
  input wire logic msg_valid,
  input wire can_framer_pkg::can_record_type msg,
  output logic msg_ready,
  output logic link_active,
  output logic serial_tx
);
  import can_framer_pkg::*;

  // ==========================================================
  // Checksum step over one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (CRC_REFLECT)
        r = (r[0] ^ b[i]) ? ((r >> 1) ^ `CRC_POLY_REFLECTED) : (r >> 1);
      else
        r = (r[15] ^ b[7-i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ==========================================================
  // Activation
  logic boot_seen;
  logic eligible;

  // Link present at boot means the host powered us: the framer stays off
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      boot_seen <= 1'b0;
      eligible <= 1'b0;
      link_active <= 1'b0;
    end
    else
    begin
      boot_seen <= boot_done;
      if (boot_done && !boot_seen)
        eligible <= can_powered && !link_connected;
      link_active <= eligible && boot_seen && link_connected;
    end
  end

  // ==========================================================
  // Framer state
  framer_state_type state;
  framer_state_type next_state;
  can_record_type record;
  logic [4:0] index;
  logic [15:0] crc;
  logic esc_pending;
  wire fifo_in_ready;

  assign msg_ready = (state == FR_IDLE) && link_active;
  wire accept = msg_valid && msg_ready;

  // Record flattened in send order, most significant byte first
  wire [7:0] app_id = record.transmitted ? `APP_ID_TRANSMITTED : `APP_ID_RECEIVED;
  wire [31:0] ident_field = {2'b00, record.extended, record.ident};
  wire [`RECORD_BITS-1:0] flat = {app_id, record.seconds, record.millis, ident_field,
                                  4'h0, record.length, record.data};
  wire [3:0] len_eff = (record.length > 4'(`MAX_DATA_BYTES)) ? 4'(`MAX_DATA_BYTES) : record.length;
  wire [4:0] last_index = 5'(`HEADER_BYTES - 1) + {1'b0, len_eff};
  wire [7:0] top_bit = 8'(`RECORD_BITS - 1) - {index, 3'b000};
  wire [7:0] record_byte = flat[top_bit -: 8];

  wire is_flag_state = (state == FR_START) || (state == FR_STOP);
  wire is_stuffed_state = (state == FR_PAYLOAD) || (state == FR_CRC_HI) || (state == FR_CRC_LO);
  wire [7:0] raw_byte = is_flag_state ? `FLAG_BYTE :
                        (state == FR_PAYLOAD) ? record_byte :
                        (state == FR_CRC_HI) ? crc[15:8] : crc[7:0];
  wire needs_escape = is_stuffed_state &&
                      ((raw_byte == `FLAG_BYTE) || (raw_byte == `ESCAPE_BYTE));
  wire [7:0] push_data = esc_pending ? (raw_byte ^ `ESCAPE_FLIP) :
                         needs_escape ? `ESCAPE_BYTE : raw_byte;
  wire push_valid = (state != FR_IDLE);
  wire push_fire = push_valid && fifo_in_ready;
  wire push_done = push_fire && (!needs_escape || esc_pending);

  always_comb
  begin
    next_state = state;
    case (state)
      FR_IDLE:
        if (accept)
          next_state = FR_START;
      FR_START:
        if (push_done)
          next_state = FR_PAYLOAD;
      FR_PAYLOAD:
        if (push_done && (index == last_index))
          next_state = FR_CRC_HI;
      FR_CRC_HI:
        if (push_done)
          next_state = FR_CRC_LO;
      FR_CRC_LO:
        if (push_done)
          next_state = FR_STOP;
      FR_STOP:
        if (push_done)
          next_state = FR_IDLE;
      default:
        next_state = FR_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= FR_IDLE;
      record <= '0;
      index <= '0;
      crc <= `CRC_INIT_DEFAULT;
      esc_pending <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (accept)
      begin
        record <= msg;
        index <= '0;
        crc <= CRC_INIT;
      end
      else if ((state == FR_PAYLOAD) && push_done)
      begin
        index <= 5'(index + 1'b1);
        crc <= crc_step(crc, raw_byte);
      end
      if (push_done)
        esc_pending <= 1'b0;
      else if (push_fire && needs_escape)
        esc_pending <= 1'b1;
    end
  end

  // ==========================================================
  // Byte buffer between framer and line
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  logic tx_busy;

  // The framer stalls on a full buffer, so nothing is dropped at 8N1 pace
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(!tx_busy)
  );

  // ==========================================================
  // 8N1 line transmitter
  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [8:0] baud_count;
  wire baud_tick = tx_busy && (baud_count == 9'(`BIT_CYCLES - 1));
  wire tx_load = fifo_out_valid && !tx_busy;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tx_shift <= 10'h3ff;
      tx_bits <= '0;
      baud_count <= '0;
      tx_busy <= 1'b0;
      serial_tx <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_shift <= {1'b1, fifo_out_data, 1'b0};
      tx_bits <= '0;
      baud_count <= '0;
      tx_busy <= 1'b1;
      serial_tx <= 1'b0;
    end
    else if (baud_tick)
    begin
      tx_shift <= {1'b1, tx_shift[9:1]};
      serial_tx <= tx_shift[1];
      tx_bits <= 4'(tx_bits + 1'b1);
      baud_count <= '0;
      if (tx_bits == 4'(`LINE_BITS - 1))
        tx_busy <= 1'b0;
    end
    else if (tx_busy)
      baud_count <= 9'(baud_count + 1'b1);
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_gate_inactive: assert property (!link_active |-> !msg_ready)
    else $error("message taken while framer inactive");
  a_frame_opens: assert property (accept |=> (state == FR_START) && (push_data == `FLAG_BYTE))
    else $error("frame does not open with flag");
  a_no_raw_flag: assert property (push_fire && is_stuffed_state |-> push_data != `FLAG_BYTE)
    else $error("unescaped flag inside frame");
  a_escape_next: assert property (push_fire && needs_escape && !esc_pending
      |=> esc_pending && (push_data == ($past(raw_byte) ^ `ESCAPE_FLIP)))
    else $error("escape not followed by flipped byte");
  a_app_id: assert property ((state == FR_PAYLOAD) && (index == 5'd0) && push_done
      |-> push_data == (record.transmitted ? `APP_ID_TRANSMITTED : `APP_ID_RECEIVED))
    else $error("wrong application identifier");
  a_ext_bit: assert property ((state == FR_PAYLOAD) && (index == 5'd7) && push_done
      |-> push_data[5] == record.extended)
    else $error("extended flag not on bit 29");
  a_crc_order: assert property ((state == FR_CRC_HI) && push_done
      |=> (state == FR_CRC_LO) && (raw_byte == $past(crc[7:0])))
    else $error("checksum bytes out of order");
  a_payload_len: assert property ($rose(state == FR_CRC_HI)
      |-> $past(index) == 5'(`HEADER_BYTES - 1) + {1'b0, len_eff})
    else $error("payload length mismatch");
  a_start_low: assert property (tx_load |=> !serial_tx && tx_busy)
    else $error("missing start bit");
  a_stop_high: assert property (tx_busy && (tx_bits == 4'(`LINE_BITS - 1)) |-> serial_tx)
    else $error("stop bit not high");
  a_bit_period: assert property (baud_count <= 9'(`BIT_CYCLES - 1))
    else $error("bit period overrun");

  c_frame_done: cover property ((state == FR_STOP) && push_done);
  c_escape_seen: cover property (push_fire && needs_escape && !esc_pending);
  c_tx_record: cover property (accept && msg.transmitted);
  c_buffer_full: cover property (push_valid && !fifo_in_ready);
endmodule

// File: common/can_framer_regs.svh
/*
  Constants of the serial message framer: byte values, record layout,
  checksum settings and byte-link timing.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef CAN_FRAMER_REGS_SVH
`define CAN_FRAMER_REGS_SVH

// ==========================================================
// Frame bytes
`define FLAG_BYTE 8'h7e
`define ESCAPE_BYTE 8'h7d
`define ESCAPE_FLIP 8'h20
`define APP_ID_RECEIVED 8'h01
`define APP_ID_TRANSMITTED 8'h02

// ==========================================================
// Record layout
`define HEADER_BYTES 12
`define MAX_DATA_BYTES 8
`define RECORD_BITS 160
`define EXTENDED_BIT 29

// ==========================================================
// Checksum
`define CRC_POLY 16'h8005
`define CRC_POLY_REFLECTED 16'ha001
`define CRC_INIT_DEFAULT 16'h0000

// ==========================================================
// Byte link timing
`define CLOCK_HZ 50000000
`define BAUD_RATE 115200
`define BIT_CYCLES (`CLOCK_HZ / `BAUD_RATE)
`define DATA_BITS 8
`define STOP_BITS 1
`define LINE_BITS (1 + `DATA_BITS + `STOP_BITS)
`define FIFO_DEPTH 8

`endif

// File: common/can_framer_pkg.sv
/*
  Types of the serial message framer: the logged message record and the
  framer states.
  Assumes the constants header is available on the include path.
*/
package can_framer_pkg;

  // ==========================================================
  // Message record handed in by the logging logic
  typedef struct packed {
    logic transmitted;
    logic [31:0] seconds;
    logic [15:0] millis;
    logic extended;
    logic [28:0] ident;
    logic [3:0] length;
    logic [0:7][7:0] data;
  } can_record_type;

  // ==========================================================
  // Framer states
  typedef enum logic [5:0] {
    FR_IDLE = 6'b000001,
    FR_START = 6'b000010,
    FR_PAYLOAD = 6'b000100,
    FR_CRC_HI = 6'b001000,
    FR_CRC_LO = 6'b010000,
    FR_STOP = 6'b100000
  } framer_state_type;

endpackage

// File: src/byte_fifo.sv
/*
  Small FIFO with valid/ready on both sides and a registered read port.
  Assumes DEPTH is a power of two and one synchronous clock.
*/
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // ==========================================================
  // Handshake decode
  wire push = in_valid && in_ready;
  wire load_out = (count != '0) && (!out_valid || out_ready);
  assign in_ready = (count != (AW+1)'(DEPTH));

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= AW'(wr_ptr + 1'b1);
      if (load_out)
      begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load_out});
    end
  end
endmodule

// File: testbench/host_link_model.sv
/*
  Host end of the serial byte link: receives 8N1 bytes, splits frames at
  flag bytes, removes escapes and checks the trailing checksum.
  Assumes the constants header is on the include path and an idle-high line.
*/
`timescale 1ns/10ps
`include "can_framer_regs.svh"
module host_link_model #(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic clock,
  input wire logic serial_tx
);
  logic [7:0] payload[$];
  logic [7:0] body[$];
  int frames = 0;
  int escapes = 0;
  int line_errors = 0;
  int stray_bytes = 0;
  logic crc_good = 1'b0;
  logic in_frame = 1'b0;
  logic escaping = 1'b0;

  // ==========================================================
  // Checksum, reflected with zero start
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] crc;
    crc = 16'h0000;
    foreach (q[i])
    begin
      crc = crc ^ {8'h00, q[i]};
      repeat (8)
        crc = crc[0] ? ((crc >> 1) ^ `CRC_POLY_REFLECTED) : (crc >> 1);
    end
    return crc;
  endfunction

  // ==========================================================
  // Frame handling
  task automatic close_frame();
    logic [15:0] sent;
    sent = {body[body.size()-2], body[body.size()-1]};
    payload = body[0:body.size()-3];
    crc_good = (crc_of(payload) === sent);
    frames++;
  endtask

  task automatic take_byte(input logic [7:0] b);
    if (b == `FLAG_BYTE)
    begin
      // A flag both closes the current body and opens the next one
      if (in_frame && body.size() >= 3)
        close_frame();
      body = {};
      in_frame = 1'b1;
      escaping = 1'b0;
    end
    else if (!in_frame)
      stray_bytes++;
    else if (b == `ESCAPE_BYTE && !escaping)
    begin
      escaping = 1'b1;
      escapes++;
    end
    else
    begin
      if (escaping && (b ^ `ESCAPE_FLIP) != `FLAG_BYTE && (b ^ `ESCAPE_FLIP) != `ESCAPE_BYTE)
        line_errors++;
      body.push_back(escaping ? (b ^ `ESCAPE_FLIP) : b);
      escaping = 1'b0;
    end
  endtask

  // ==========================================================
  // Byte receiver, sampling each bit near its middle
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(posedge clock);
      if (serial_tx === 1'b0)
      begin
        repeat (BIT_CYCLES / 2) @(posedge clock);
        if (serial_tx !== 1'b0)
          line_errors++;
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYCLES) @(posedge clock);
          b[i] = serial_tx;
        end
        repeat (BIT_CYCLES) @(posedge clock);
        if (serial_tx !== 1'b1)
          line_errors++;
        take_byte(b);
      end
    end
  end
endmodule

// File: testbench/tb.sv
/*
  Self-checking bench of the serial message framer: activation cases and
  one full stuffed frame decoded by the host model.
  Assumes the package, constants header and host model are compiled first.
*/
`timescale 1ns/10ps
`include "can_framer_regs.svh"
module tb;
  import can_framer_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic boot_done = 1'b0;
  logic can_powered = 1'b0;
  logic link_connected = 1'b0;
  logic msg_valid = 1'b0;
  can_record_type msg = '0;
  logic msg_ready;
  logic link_active;
  logic serial_tx;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] expect_bytes[$];

  always #10 clock = ~clock;

  can_msg_serial_framer i_dut (
    .clock(clock),
    .reset(reset),
    .boot_done(boot_done),
    .can_powered(can_powered),
    .link_connected(link_connected),
    .msg_valid(msg_valid),
    .msg(msg),
    .msg_ready(msg_ready),
    .link_active(link_active),
    .serial_tx(serial_tx)
  );

  host_link_model i_host (
    .clock(clock),
    .serial_tx(serial_tx)
  );

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic apply_reset();
    reset = 1'b1;
    boot_done = 1'b0;
    can_powered = 1'b0;
    link_connected = 1'b0;
    cycles(12);
    reset = 1'b0;
    cycles(2);
  endtask

  // ==========================================================
  // Scenarios
  task automatic try_activation(input logic powered, input logic early_link, input logic exp);
    apply_reset();
    check_bit(serial_tx, 1'b1, "idle line");
    can_powered = powered;
    link_connected = early_link;
    cycles(2);
    boot_done = 1'b1;
    cycles(3);
    check_bit(link_active, 1'b0, "active before link");
    link_connected = 1'b1;
    cycles(4);
    check_bit(link_active, exp, "link active");
    check_bit(msg_ready, exp, "ready after activation");
  endtask

  task automatic send_frame();
    int waited;
    msg.transmitted = 1'b1;
    msg.seconds = 32'h7e12_7d34;
    msg.millis = 16'h0abc;
    msg.extended = 1'b1;
    msg.ident = 29'h1234_5678;
    msg.length = 4'h1;
    msg.data = 64'h5a7e_1122_3344_5566;
    expect_bytes = {8'h02, 8'h7e, 8'h12, 8'h7d, 8'h34, 8'h0a, 8'hbc,
                    8'h32, 8'h34, 8'h56, 8'h78, 8'h01, 8'h5a};
    msg_valid = 1'b1;
    waited = 0;
    while (msg_ready !== 1'b1 && waited < 20)
    begin
      cycles(1);
      waited++;
    end
    if (msg_ready !== 1'b1)
    begin
      miscompares++;
      $display("MISMATCH at %0t: message never taken", $time);
      stop_test();
    end
    cycles(1);
    msg_valid = 1'b0;
    check_bit(msg_ready, 1'b0, "busy after accept");
    waited = 0;
    while (i_host.frames == 0 && waited < 100000)
    begin
      cycles(1);
      waited++;
    end
    if (i_host.frames == 0)
    begin
      miscompares++;
      $display("MISMATCH at %0t: no frame decoded", $time);
      stop_test();
    end
    check_bit(i_host.payload.size() == expect_bytes.size(), 1'b1, "payload size");
    foreach (expect_bytes[i])
      check_byte(i_host.payload[i], expect_bytes[i], "payload byte");
    check_bit(i_host.crc_good, 1'b1, "checksum");
    check_bit(i_host.escapes >= 2, 1'b1, "escapes used");
    check_bit(i_host.line_errors == 0, 1'b1, "line format");
    check_bit(i_host.stray_bytes == 0, 1'b1, "bytes outside flags");
    check_bit(msg_ready, 1'b1, "ready after frame");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    try_activation(1'b0, 1'b0, 1'b0);
    try_activation(1'b1, 1'b1, 1'b0);
    try_activation(1'b1, 1'b0, 1'b1);
    send_frame();
    stop_test();
  end
endmodule
